// ==== adc_seq_defs.vh ====
// Purpose: shared constants for the converter mode sequencer
// Assumes: 8-bit special function register port of the core
// Notes: register addresses below are local choices
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// ==========================================================
// register addresses
`define ADDR_MODE 8'hD1
`define ADDR_STAT 8'hD8
`define ADDR_PCHAN 8'hE6
`define ADDR_AUXCTL 8'hD3
`define ADDR_AUXCFGA 8'hD4
`define ADDR_AUXCFGB 8'hD5

// ==========================================================
// mode register fields
`define MODE_RESET 8'h00
`define MODE_PEN 5
`define MODE_AEN 4
`define MODE_CHOPDIS 3
`define MODE_OP 2:0
`define MODE_USED 8'h3F

// ==========================================================
// operation select codes
`define OP_PDOWN 3'h0
`define OP_IDLE 3'h1
`define OP_SINGLE 3'h2
`define OP_CONT 3'h3
`define OP_ZS_INT 3'h4
`define OP_FS_INT 3'h5
`define OP_CAL 2

// ==========================================================
// status register fields
`define STAT_PRDY 7
`define STAT_ARDY 6
`define STAT_AERR 4
`define STAT_RESET 8'h00

// ==========================================================
// channel select fields and timing
`define PCHAN_RESET 8'h00
`define AUXCTL_RESET 8'h00
`define PCHAN_REF 7:6
`define PCHAN_IN 3:0
`define AUXCTL_REF 6
`define AUXCTL_IN 3:0
`define CAL_OUTS_CHOP 3'h2
`define CAL_OUTS_NOCHOP 3'h4
`define ALIGN_OUTS 2'h3
`define TEMP_INPUT 4'hF

`endif

// ==== converter_lane.v ====
// Purpose: run one converter through the selected operation
// Assumes: out_strobe is a one-cycle filter output pulse on mclk
// Notes: a restart drops any conversion in flight
`timescale 1ns/1ps
`include "adc_seq_defs.vh"

module converter_lane
(
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // control
  input wire active,
  input wire restart,
  input wire [2:0] op,
  input wire chop_dis,
  // filter side
  input wire out_strobe,
  output wire mod_clk_en,
  output wire filt_rst,
  // events
  output wire result_we,
  output wire cal_done,
  output wire running,
  output wire finished
);

  localparam ST_OFF = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_FIN = 2'b10;

  reg [1:0] st;
  reg [2:0] cnt;
  wire live;
  wire is_cal;
  wire [2:0] cal_len;

  // ==========================================================
  // event decode
  assign live = active && !restart && (st == ST_RUN) && out_strobe;
  assign is_cal = op[`OP_CAL];
  assign cal_len = chop_dis ? `CAL_OUTS_NOCHOP : `CAL_OUTS_CHOP;
  assign result_we = live && (op == `OP_SINGLE || op == `OP_CONT);
  assign cal_done = live && is_cal && (cnt + 3'h1 == cal_len);
  assign mod_clk_en = (st != ST_OFF);
  assign filt_rst = (st != ST_RUN) || (op == `OP_IDLE);
  assign running = (st == ST_RUN) && (op != `OP_IDLE);
  assign finished = (st == ST_FIN);

  // ==========================================================
  // sequence
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= ST_OFF;
      cnt <= 3'h0;
    end
    else if (!active || restart)
    begin
      st <= active ? ST_RUN : ST_OFF;
      cnt <= 3'h0;
    end
    else
    begin
      case (st)
        ST_OFF:
          st <= ST_RUN;
        ST_RUN:
          if (cal_done || (result_we && op == `OP_SINGLE))
            st <= ST_FIN;
          else if (live && is_cal)
            cnt <= cnt + 3'h1;
        ST_FIN:
          st <= ST_FIN;
        default:
          st <= ST_OFF;
      endcase
    end
  end

endmodule // converter_lane

// ==== aux_step_align.v ====
// Purpose: hold the auxiliary converter until it is in step
// Assumes: primary strobes arrive on mclk
// Notes: gives up waiting as soon as the primary stops
`timescale 1ns/1ps
`include "adc_seq_defs.vh"

module aux_step_align
(
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // events
  input wire start,
  input wire prim_busy,
  input wire prim_strobe,
  // gate
  output wire hold
);

  reg waiting;
  reg [1:0] seen;

  assign hold = waiting;

  // ==========================================================
  // alignment
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waiting <= 1'b0;
      seen <= 2'h0;
    end
    else if (start)
    begin
      waiting <= prim_busy;
      seen <= 2'h0;
    end
    else if (waiting && !prim_busy)
      waiting <= 1'b0;
    else if (waiting && prim_strobe)
    begin
      seen <= seen + 2'h1;
      if (seen + 2'h1 == `ALIGN_OUTS)
        waiting <= 1'b0;
    end
  end

endmodule // aux_step_align

// ==== adc_mode_sequencer.v ====
// Purpose: mode and calibration sequencer for two converters
// Assumes: core register port and filters all run on mclk
// Notes: analog switching is only signalled, not modelled here
// Function
// - mode field acts only on converters that are enabled
// - mode 000 is power-down and the reset value
// - idle holds filter and modulator reset, clocks still run
// - single conversion updates result and flags, then writes 000
// - continuous mode keeps updating results and never leaves
// - internal zero-scale cal shorts the enabled inputs
// - internal full-scale cal routes selected reference to inputs
// - system zero-scale cal uses selected channel, no internal source
// - system full-scale cal uses selected channel inputs
// - changing the mode field resets both converters
// - rewriting the same mode value still resets
// - aux config write with primary on, or primary enable rise
// - aux control write resets aux only; aux enable rise is a mode write and resets both
// - aux realigns to primary outputs, up to three outputs late
// - aux starts at once when primary already finished
// - core sleep keeps mode register, operation restarts on wake
// - cal write clears ready flags; end writes cal, flags, 000
// - aux cal on temperature input: ready, no cal write, error
// - calibration takes two outputs chopped, four unchopped
// - primary enable runs primary in mode, clear powers down
// - aux enable runs aux in mode, clear powers down
// - chop disable bit clear enables chopping on both
`timescale 1ns/1ps
`include "adc_seq_defs.vh"

module adc_mode_sequencer
#(
  parameter RESULT_W = 24
)
(
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // special function register port
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_we,
  output reg [7:0] sfr_rdata,
  // core power state
  input wire core_sleep_request,
  // primary filter side
  input wire prim_out_strobe,
  input wire [RESULT_W-1:0] prim_sample,
  output wire prim_mod_clk_en,
  output wire prim_filt_rst,
  output wire prim_input_short,
  output wire prim_ref_route,
  output wire prim_cal_we,
  // auxiliary filter side
  input wire aux_out_strobe,
  input wire [RESULT_W-1:0] aux_sample,
  output wire aux_mod_clk_en,
  output wire aux_filt_rst,
  output wire aux_input_short,
  output wire aux_ref_route,
  output wire aux_cal_we,
  // shared analog settings
  output wire chop_enable,
  output wire cal_full_scale,
  output wire [1:0] reference_source_select,
  output wire aux_reference_source_select,
  output wire [3:0] primary_input_select,
  output wire [3:0] aux_input_select,
  // results
  output reg [RESULT_W-1:0] primary_result_bytes,
  output reg [RESULT_W-1:0] aux_result_bytes
);

  // ==========================================================
  // register state
  reg [7:0] converter_mode_register;
  reg [7:0] converter_status_register;
  reg [7:0] primary_channel_select_register;
  reg [7:0] aux_control_register;
  reg rst_both;
  reg rst_aux;
  reg align_start;

  wire [2:0] operation_select_field;
  wire primary_converter_enable;
  wire aux_converter_enable;
  wire chop_disable;
  wire primary_result_ready;
  wire aux_result_ready;
  wire aux_error_flag;

  // ==========================================================
  // write decode
  wire wr_mode;
  wire wr_stat;
  wire wr_pchan;
  wire wr_auxctl;
  wire wr_auxcfg;
  wire pen_rise;
  wire aen_rise;
  wire next_cal;

  assign wr_mode = sfr_we && (sfr_addr == `ADDR_MODE);
  assign wr_stat = sfr_we && (sfr_addr == `ADDR_STAT);
  assign wr_pchan = sfr_we && (sfr_addr == `ADDR_PCHAN);
  assign wr_auxctl = sfr_we && (sfr_addr == `ADDR_AUXCTL);
  assign wr_auxcfg = sfr_we &&
    (sfr_addr == `ADDR_AUXCFGA || sfr_addr == `ADDR_AUXCFGB);
  assign pen_rise = wr_mode && sfr_wdata[`MODE_PEN] &&
    !primary_converter_enable;
  assign aen_rise = wr_mode && sfr_wdata[`MODE_AEN] &&
    !aux_converter_enable;
  assign next_cal = sfr_wdata[`OP_CAL];

  // ==========================================================
  // field views
  assign operation_select_field = converter_mode_register[`MODE_OP];
  assign primary_converter_enable = converter_mode_register[`MODE_PEN];
  assign aux_converter_enable = converter_mode_register[`MODE_AEN];
  assign chop_disable = converter_mode_register[`MODE_CHOPDIS];
  assign primary_result_ready = converter_status_register[`STAT_PRDY];
  assign aux_result_ready = converter_status_register[`STAT_ARDY];
  assign aux_error_flag = converter_status_register[`STAT_AERR];
  assign reference_source_select =
    primary_channel_select_register[`PCHAN_REF];
  assign primary_input_select = primary_channel_select_register[`PCHAN_IN];
  assign aux_reference_source_select = aux_control_register[`AUXCTL_REF];
  assign aux_input_select = aux_control_register[`AUXCTL_IN];
  assign chop_enable = !chop_disable;

  // ==========================================================
  // lane control
  wire op_live;
  wire prim_active;
  wire aux_active;
  wire aux_hold;
  wire p_result_we;
  wire p_cal_done;
  wire p_running;
  wire p_fin;
  wire a_result_we;
  wire a_cal_done;
  wire a_running;
  wire a_fin;
  wire aux_on_temp;
  wire all_fin;
  wire op_ends;

  assign op_live = (operation_select_field != `OP_PDOWN);
  assign prim_active = primary_converter_enable && op_live &&
    !core_sleep_request;
  assign aux_active = aux_converter_enable && op_live &&
    !core_sleep_request && !aux_hold;
  assign aux_on_temp = (aux_input_select == `TEMP_INPUT);

  converter_lane u_prim
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .active(prim_active),
    .restart(rst_both),
    .op(operation_select_field),
    .chop_dis(chop_disable),
    .out_strobe(prim_out_strobe),
    .mod_clk_en(prim_mod_clk_en),
    .filt_rst(prim_filt_rst),
    .result_we(p_result_we),
    .cal_done(p_cal_done),
    .running(p_running),
    .finished(p_fin)
  );

  converter_lane u_aux
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .active(aux_active),
    .restart(rst_both | rst_aux),
    .op(operation_select_field),
    .chop_dis(chop_disable),
    .out_strobe(aux_out_strobe),
    .mod_clk_en(aux_mod_clk_en),
    .filt_rst(aux_filt_rst),
    .result_we(a_result_we),
    .cal_done(a_cal_done),
    .running(a_running),
    .finished(a_fin)
  );

  // aux-only restarts wait for the primary output cycle
  aux_step_align u_align
  (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(align_start),
    .prim_busy(p_running && prim_active),
    .prim_strobe(prim_out_strobe),
    .hold(aux_hold)
  );

  // ==========================================================
  // calibration routing
  // short for internal zero
  assign prim_input_short = prim_active &&
    (operation_select_field == `OP_ZS_INT);
  assign aux_input_short = aux_active &&
    (operation_select_field == `OP_ZS_INT);
  assign prim_ref_route = prim_active &&
    (operation_select_field == `OP_FS_INT);
  assign aux_ref_route = aux_active &&
    (operation_select_field == `OP_FS_INT);
  assign cal_full_scale = operation_select_field[0];
  assign prim_cal_we = p_cal_done;
  assign aux_cal_we = a_cal_done && !aux_on_temp;

  // ==========================================================
  // end of a one-shot operation
  // only enabled lanes count
  assign all_fin = (!primary_converter_enable || p_fin) &&
    (!aux_converter_enable || a_fin) &&
    (primary_converter_enable || aux_converter_enable);
  assign op_ends = all_fin && !core_sleep_request &&
    (operation_select_field == `OP_SINGLE ||
    operation_select_field[`OP_CAL]);

  // ==========================================================
  // mode register
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      converter_mode_register <= `MODE_RESET;
    else if (wr_mode)
      converter_mode_register <= sfr_wdata & `MODE_USED;
    else if (op_ends)
    begin
      converter_mode_register[`MODE_OP] <= `OP_PDOWN;
    end
  end

  // ==========================================================
  // converter reset requests
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_both <= 1'b0;
      rst_aux <= 1'b0;
      align_start <= 1'b0;
    end
    else
    begin
      rst_both <= wr_mode || pen_rise ||
        (wr_auxcfg && primary_converter_enable);
      rst_aux <= wr_auxctl || aen_rise ||
        (wr_auxcfg && !primary_converter_enable);
      align_start <= (wr_auxctl || aen_rise ||
        (wr_auxcfg && !primary_converter_enable)) &&
        !(wr_mode && !aen_rise);
    end
  end

  // ==========================================================
  // channel and aux control registers
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primary_channel_select_register <= `PCHAN_RESET;
      aux_control_register <= `AUXCTL_RESET;
    end
    else
    begin
      if (wr_pchan)
        primary_channel_select_register <= sfr_wdata;
      if (wr_auxctl)
        aux_control_register <= sfr_wdata;
    end
  end

  // ==========================================================
  // status flags: a hardware set beats any clear in the same cycle
  wire p_set;
  wire a_set;
  wire e_set;
  wire cal_clr;

  assign p_set = p_result_we || p_cal_done;
  assign a_set = a_result_we || a_cal_done;
  assign e_set = a_cal_done && aux_on_temp;
  assign cal_clr = wr_mode && next_cal;

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      converter_status_register <= `STAT_RESET;
    else
    begin
      if (p_set)
        converter_status_register[`STAT_PRDY] <= 1'b1;
      else if (cal_clr || (wr_stat && !sfr_wdata[`STAT_PRDY]))
        converter_status_register[`STAT_PRDY] <= 1'b0;
      if (a_set)
        converter_status_register[`STAT_ARDY] <= 1'b1;
      else if (cal_clr || (wr_stat && !sfr_wdata[`STAT_ARDY]))
        converter_status_register[`STAT_ARDY] <= 1'b0;
      if (e_set)
        converter_status_register[`STAT_AERR] <= 1'b1;
      else if (wr_stat && !sfr_wdata[`STAT_AERR])
        converter_status_register[`STAT_AERR] <= 1'b0;
    end
  end

  // ==========================================================
  // result registers
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      primary_result_bytes <= {RESULT_W{1'b0}};
      aux_result_bytes <= {RESULT_W{1'b0}};
    end
    else
    begin
      if (p_result_we)
        primary_result_bytes <= prim_sample;
      if (a_result_we)
        aux_result_bytes <= aux_sample;
    end
  end

  // ==========================================================
  // read port, one cycle behind the address
  reg [7:0] next_rdata;

  always @*
  begin
    case (sfr_addr)
      `ADDR_MODE:
        next_rdata = converter_mode_register;
      `ADDR_STAT:
        next_rdata = converter_status_register;
      `ADDR_PCHAN:
        next_rdata = primary_channel_select_register;
      `ADDR_AUXCTL:
        next_rdata = aux_control_register;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end

  // status bits not listed stay zero: only defined bits are ever set
  wire unused_ok;
  assign unused_ok = primary_result_ready | aux_result_ready |
    aux_error_flag | a_running;

endmodule // adc_mode_sequencer

// ==== adc_mode_sequencer_properties.sv ====
// Purpose: port-level properties of the mode sequencer
// Assumes: one mclk domain, arst_n asynchronous active low
// Notes: mode state is inferred from register writes alone
`timescale 1ns/1ps

module adc_mode_sequencer_properties
#(
  parameter RESULT_W = 24
)
(
  // clock and reset
  input wire mclk,
  input wire arst_n,
  // register port
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_we,
  input wire core_sleep_request,
  // converter side
  input wire prim_out_strobe,
  input wire prim_mod_clk_en,
  input wire prim_filt_rst,
  input wire prim_input_short,
  input wire prim_ref_route,
  input wire prim_cal_we,
  input wire aux_mod_clk_en,
  input wire aux_cal_we,
  input wire [3:0] aux_input_select,
  input wire chop_enable,
  input wire [RESULT_W-1:0] primary_result_bytes
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // ==========
  // helpers
  wire mode_wr = sfr_we && (sfr_addr == 8'hD1);
  wire prim_wr = mode_wr && sfr_wdata[5] && !core_sleep_request;
  // two quiet cycles so a later write cannot mask the result
  wire quiet = !sfr_we && !core_sleep_request;

  // ==========
  // assertions
  AST_IDLE_CLOCKS: assert property (
    prim_wr && sfr_wdata[2:0] == 3'h1 ##1 quiet ##1 quiet |->
    prim_mod_clk_en && prim_filt_rst)
    else $error("idle mode lost clock or filter reset");
  AST_ZERO_SHORT: assert property (
    prim_wr && sfr_wdata[2:0] == 3'h4 ##1 quiet ##1 quiet |->
    prim_input_short && !prim_ref_route)
    else $error("zero-scale cal without input short");
  AST_FULL_REF: assert property (
    prim_wr && sfr_wdata[2:0] == 3'h5 ##1 quiet ##1 quiet |->
    prim_ref_route && !prim_input_short)
    else $error("full-scale cal without reference route");
  AST_SYS_CAL: assert property (
    prim_wr && sfr_wdata[2:1] == 2'h3 ##1 quiet ##1 quiet |->
    !prim_input_short && !prim_ref_route && !prim_filt_rst)
    else $error("system cal switched an internal source");
  AST_PRIM_OFF: assert property (
    mode_wr && !sfr_wdata[5] ##1 quiet ##1 quiet |->
    !prim_mod_clk_en && prim_filt_rst)
    else $error("primary ran while disabled");
  AST_CHOP: assert property (
    mode_wr |=> chop_enable == !$past(sfr_wdata[3]))
    else $error("chop enable does not follow mode write");
  AST_RESTART_DROP: assert property (
    mode_wr |-> ##2 $stable(primary_result_bytes))
    else $error("result updated in restart cycle");
  AST_RESULT_CAUSE: assert property (
    $changed(primary_result_bytes) |-> $past(prim_out_strobe))
    else $error("result changed without filter output");
  AST_CAL_ON_STROBE: assert property (
    prim_cal_we |-> prim_out_strobe)
    else $error("cal write outside a filter output");
  AST_TEMP_NO_CAL: assert property (
    aux_input_select == 4'hF |-> !aux_cal_we)
    else $error("aux cal written on temperature input");
  AST_SLEEP_OFF: assert property (
    core_sleep_request [*2] |-> !prim_mod_clk_en && !aux_mod_clk_en)
    else $error("converter clocked during core sleep");

  // ==========
  // coverage
  cover property (prim_cal_we);
  cover property (prim_wr && sfr_wdata[2:0] == 3'h3);
  cover property (core_sleep_request [*2]);
endmodule // adc_mode_sequencer_properties

bind adc_mode_sequencer adc_mode_sequencer_properties
  #(.RESULT_W(RESULT_W)) props
  (.mclk(mclk), .arst_n(arst_n), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
  .core_sleep_request(core_sleep_request),
  .prim_out_strobe(prim_out_strobe), .prim_mod_clk_en(prim_mod_clk_en),
  .prim_filt_rst(prim_filt_rst), .prim_input_short(prim_input_short),
  .prim_ref_route(prim_ref_route), .prim_cal_we(prim_cal_we),
  .aux_mod_clk_en(aux_mod_clk_en), .aux_cal_we(aux_cal_we),
  .aux_input_select(aux_input_select), .chop_enable(chop_enable),
  .primary_result_bytes(primary_result_bytes));

// ==== adc_mode_sequencer_tb.sv ====
// Purpose: self-checking bench for the mode sequencer
// Assumes: filter strobes are driven by the bench
// Notes: alignment delay is pinned: aux holds through the second primary output and resumes after the third
`timescale 1ns/1ps

module adc_mode_sequencer_tb;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_we = 1'b0;
  reg core_sleep_request = 1'b0;
  reg prim_out_strobe = 1'b0;
  reg aux_out_strobe = 1'b0;
  reg [23:0] prim_sample = 24'h000000;
  reg [23:0] aux_sample = 24'h000000;
  wire [7:0] sfr_rdata;
  wire prim_mod_clk_en, prim_filt_rst, prim_input_short, prim_ref_route;
  wire prim_cal_we, aux_mod_clk_en, aux_cal_we, chop_enable;
  wire [3:0] aux_input_select;
  wire aux_filt_rst, aux_input_short, aux_ref_route, cal_full_scale;
  wire aux_reference_source_select;
  wire [1:0] reference_source_select;
  wire [3:0] primary_input_select;
  wire [23:0] primary_result_bytes, aux_result_bytes;
  integer seed = 15047;
  integer n_errors = 0;
  integer n_tests = 0;
  integer n_pcal = 0;
  integer n_acal = 0;
  integer i, k, c, m;
  reg [23:0] ps, as, hold;

  adc_mode_sequencer dut (.mclk(mclk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_rdata(sfr_rdata),
    .core_sleep_request(core_sleep_request), .prim_out_strobe(prim_out_strobe),
    .prim_sample(prim_sample), .prim_mod_clk_en(prim_mod_clk_en),
    .prim_filt_rst(prim_filt_rst), .prim_input_short(prim_input_short),
    .prim_ref_route(prim_ref_route), .prim_cal_we(prim_cal_we),
    .aux_out_strobe(aux_out_strobe), .aux_sample(aux_sample),
    .aux_mod_clk_en(aux_mod_clk_en), .aux_filt_rst(aux_filt_rst),
    .aux_input_short(aux_input_short), .aux_ref_route(aux_ref_route),
    .aux_cal_we(aux_cal_we), .chop_enable(chop_enable),
    .cal_full_scale(cal_full_scale),
    .reference_source_select(reference_source_select),
    .aux_reference_source_select(aux_reference_source_select),
    .primary_input_select(primary_input_select),
    .aux_input_select(aux_input_select),
    .primary_result_bytes(primary_result_bytes),
    .aux_result_bytes(aux_result_bytes));

  // ==========
  // clock and cal pulse counters
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (prim_cal_we === 1'b1) n_pcal = n_pcal + 1;
    if (aux_cal_we === 1'b1) n_acal = n_acal + 1;
  end

  // ==========
  // expectations
  function [7:0] mode_byte(input p, input a, input ch, input [2:0] op);
    mode_byte = {2'b00, p, a, ch, op};
  endfunction
  function integer cal_len(input ch);
    cal_len = ch ? 4 : 2;
  endfunction

  // ==========
  // bus and filter tasks
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // st puts a filter output into the restart cycle
  task wr(input [7:0] a, input [7:0] d, input st);
  begin
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_we <= 1'b1;
    @(posedge mclk);
    sfr_we <= 1'b0;
    prim_out_strobe <= st;
    aux_out_strobe <= st;
    @(posedge mclk);
    prim_out_strobe <= 1'b0;
    aux_out_strobe <= 1'b0;
    #1;
  end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
  begin
    @(posedge mclk);
    sfr_addr <= a;
    @(posedge mclk);
    #1 chk(sfr_rdata, exp);
  end
  endtask
  task stb(input p, input a);
  begin
    @(posedge mclk);
    ps = $random(seed);
    as = $random(seed);
    prim_sample <= ps;
    aux_sample <= as;
    prim_out_strobe <= p;
    aux_out_strobe <= a;
    @(posedge mclk);
    prim_out_strobe <= 1'b0;
    aux_out_strobe <= 1'b0;
    @(posedge mclk);
    #1;
  end
  endtask
  task report_and_stop;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  // ==========
  // watchdog, far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors = n_errors + 1;
    report_and_stop;
  end

  // ==========
  // scenarios
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    #1 chk(prim_filt_rst, 1);
    chk(chop_enable, 1);
    rd(8'hD1, 8'h00);
    m = $random(seed);
    wr(8'h10, m[7:0], 1'b0);
    rd(8'h10, 8'h00);
    wr(8'hE6, 8'hC5, 1'b0);
    chk(reference_source_select, 3);
    chk(primary_input_select, 5);
    rd(8'hE6, 8'hC5);
    $display("test reset done");
    wr(8'hD1, mode_byte(1, 0, 0, 3'h2), 1'b0);
    stb(1'b1, 1'b0);
    chk(primary_result_bytes, ps);
    rd(8'hD1, mode_byte(1, 0, 0, 3'h0));
    rd(8'hD8, 8'h80);
    chk(prim_mod_clk_en, 0);
    $display("test single done");
    wr(8'hD1, mode_byte(1, 0, 0, 3'h3), 1'b0);
    for (i = 0; i < 4; i = i + 1)
    begin
      stb(1'b1, 1'b0);
      chk(primary_result_bytes, ps);
    end
    rd(8'hD1, mode_byte(1, 0, 0, 3'h3));
    for (i = 0; i < 3; i = i + 1)
    begin
      hold = primary_result_bytes;
      wr(i == 0 ? 8'hD1 : 8'hD3 + i, i == 0 ? 8'h23 : 8'h00, 1'b1);
      chk(primary_result_bytes, hold);
      stb(1'b1, 1'b0);
      chk(primary_result_bytes, ps);
    end
    $display("test restart done");
    for (c = 0; c < 2; c = c + 1)
      for (k = 4; k < 8; k = k + 1)
      begin
        m = n_pcal;
        wr(8'hD1, mode_byte(1, 0, c, k), 1'b0);
        chk(prim_input_short, k == 4);
        chk(prim_ref_route, k == 5);
        chk(chop_enable, c == 0);
        chk(cal_full_scale, k == 5 || k == 7);
        rd(8'hD8, 8'h00);
        for (i = 1; i < cal_len(c); i = i + 1)
          stb(1'b1, 1'b0);
        rd(8'hD1, mode_byte(1, 0, c, k));
        stb(1'b1, 1'b0);
        chk(n_pcal - m, 1);
        rd(8'hD1, mode_byte(1, 0, c, 3'h0));
        rd(8'hD8, 8'h80);
      end
    $display("test calibration done");
    wr(8'hD8, 8'h00, 1'b0);
    wr(8'hD3, 8'h0F, 1'b0);
    wr(8'hD1, mode_byte(0, 1, 0, 3'h4), 1'b0);
    chk(aux_input_short, 1);
    chk(aux_ref_route, 0);
    stb(1'b0, 1'b1);
    stb(1'b0, 1'b1);
    chk(n_acal, 0);
    rd(8'hD8, 8'h50);
    $display("test aux temperature cal done");
    wr(8'hD3, 8'h01, 1'b0);
    wr(8'hD1, mode_byte(1, 1, 0, 3'h3), 1'b0);
    hold = aux_result_bytes;
    wr(8'hD3, 8'h02, 1'b0);
    stb(1'b1, 1'b0);
    chk(primary_result_bytes, ps);
    stb(1'b0, 1'b1);
    chk(aux_result_bytes, hold);
    for (i = 0; i < 4; i = i + 1)
    begin
      stb(1'b1, 1'b0);
      stb(1'b0, 1'b1);
      chk(aux_result_bytes, i == 0 ? hold : as);
    end
    chk(aux_result_bytes, as);
    $display("test aux alignment done");
    @(posedge mclk);
    core_sleep_request <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(prim_mod_clk_en, 0);
    hold = primary_result_bytes;
    stb(1'b1, 1'b0);
    chk(primary_result_bytes, hold);
    rd(8'hD1, mode_byte(1, 1, 0, 3'h3));
    @(posedge mclk);
    core_sleep_request <= 1'b0;
    repeat (3) @(posedge mclk);
    stb(1'b1, 1'b0);
    chk(primary_result_bytes, ps);
    $display("test sleep done");
    wr(8'hD1, mode_byte(1, 1, 0, 3'h2), 1'b0);
    stb(1'b1, 1'b0);
    wr(8'hD3, 8'h43, 1'b0);
    chk(aux_reference_source_select, 1);
    stb(1'b0, 1'b1);
    chk(aux_result_bytes, as);
    rd(8'hD1, mode_byte(1, 1, 0, 3'h0));
    $display("test aux late start done");
    wr(8'hD1, mode_byte(1, 0, 0, 3'h1), 1'b0);
    chk(prim_mod_clk_en, 1);
    chk(prim_filt_rst, 1);
    chk(aux_filt_rst, 1);
    hold = primary_result_bytes;
    stb(1'b1, 1'b0);
    chk(primary_result_bytes, hold);
    $display("test idle done");
    report_and_stop;
  end
endmodule // adc_mode_sequencer_tb
